// ===== common/lfus_pkg.sv
// Constants for the LED fault and serial receive status register group
package lfus_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_SERIAL_ERR = 8'h11;
  localparam logic [7:0] ADDR_SHORT = 8'h12;
  localparam logic [7:0] ADDR_OPEN = 8'h13;
  localparam logic [7:0] ADDR_TRACE = 8'h14;
  // Register data width and vector width
  localparam int REG_W = 13;
  localparam int DRV_N = 12;
  // Serial error flag positions
  localparam int BIT_WATCHDOG = 8;
  localparam int BIT_TIMEOUT = 7;
  localparam int BIT_CHECKSUM = 6;
  localparam int BIT_SYNC_PAR = 5;
  localparam int BIT_PL_PAR = 4;
  localparam int BIT_SYNC_STOP = 3;
  localparam int BIT_PL_STOP = 2;
  localparam int BIT_PL_START = 1;
  // Mask of implemented serial flags, bits 8:1
  localparam logic [12:0] SERIAL_MASK = 13'h01fe;
  // Summary bit positions in the general status word
  localparam int SUM_SERIAL = 6;
  localparam int SUM_TRACE = 5;
  localparam int SUM_OPEN = 4;
  localparam int SUM_SHORT = 3;
  // Reset values
  localparam logic [12:0] RST_VAL = 13'h0000;
  // Receive timeout in bit periods
  localparam int TIMEOUT_BITS = 16;
endpackage

// ===== rtl/lfus_flag_bank.sv
// Generic sticky write-one-to-clear flag bank
`timescale 1ns/1ps
module lfus_flag_bank #(
  parameter int W = 12
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Hardware set events and software clear mask
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  // Stored flags
  output logic [W-1:0] flags_q
);
  logic [W-1:0] flags_d; // Next flag state

  // Set wins over clear so an event in the clearing cycle survives
  always_comb begin
    flags_d = (flags_q & ~clr_i) | set_i;
  end

  // Registered flags, cleared at reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end
endmodule

// ===== rtl/lfus_status_regs.sv
// Serial receive error and LED fault status registers with summary bits
`timescale 1ns/1ps
module lfus_status_regs #(
  parameter int CYC_PER_BIT = 10, // Core clocks per serial bit period
  parameter int WD_CNT_W = 16 // Width of the inactivity counter
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Serial receive pin, asynchronous
  input wire logic rx_pin,
  // Receiver between-frames indication, same clock
  input wire logic rx_idle_between,
  // Receiver error events, one-cycle pulses, same clock
  input wire logic checksum_fail,
  input wire logic sync_frame_parity_err,
  input wire logic payload_parity_err,
  input wire logic sync_frame_stop_err,
  input wire logic payload_stopbit_err,
  input wire logic payload_startbit_err,
  // Inactivity duration from the serial configuration register, in core clocks
  input wire logic [WD_CNT_W-1:0] inactivity_duration_field,
  // Per-driver fault detection pulses
  input wire logic [11:0] short_detect,
  input wire logic [11:0] open_detect,
  input wire logic [11:0] trace_detect,
  // Register access from the serial command decoder
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [12:0] reg_wdata,
  // Read data and valid strobe
  output logic [12:0] reg_rdata_q,
  output logic reg_rvalid_q,
  // Transaction rejected for bad checksum
  output logic reject_q,
  // Switches forced to the watchdog state
  output logic force_wd_state_q,
  // General status summary bits
  output logic any_serial_summary_q,
  output logic open_trace_summary_q,
  output logic any_open_summary_q,
  output logic any_short_summary_q
);
  // Cycles of silence before a receive timeout
  localparam int TO_CYC = lfus_pkg::TIMEOUT_BITS * CYC_PER_BIT;
  localparam int TO_W = $clog2(TO_CYC + 1);

  // Refuse parameters the counters cannot serve, at elaboration
  if (CYC_PER_BIT < 1 || WD_CNT_W < 1) begin : g_bad_param
    $error("lfus_status_regs: bad parameters");
  end

  // Pin synchroniser; first stage read only by the second
  logic rx_s1_q, rx_s1_d;
  logic rx_s2_q, rx_s2_d;
  logic rx_prev_q, rx_prev_d; // Last synchronised level for edge detect
  logic rx_edge; // Transition on the receive line
  // Silence counters
  logic [WD_CNT_W-1:0] wd_cnt_q, wd_cnt_d;
  logic [TO_W-1:0] to_cnt_q, to_cnt_d;
  logic wd_hit, to_hit; // Counter expiry pulses
  logic wd_arm_q, wd_arm_d; // One flag per silent stretch
  logic to_arm_q, to_arm_d;
  // Flag bank plumbing
  logic [12:0] ser_set, ser_clr, ser_flags;
  logic [11:0] sh_clr, op_clr, tr_clr;
  logic [11:0] sh_flags, op_flags, tr_flags;
  logic wr_ser, wr_sh, wr_op, wr_tr; // Address decode
  // Output next values
  logic [12:0] rdata_d;
  logic rvalid_d, reject_d, force_d;
  logic sum_ser_d, sum_tr_d, sum_op_d, sum_sh_d;

  // Synchroniser, edge detect and silence counters
  always_comb begin
    rx_s1_d = rx_pin;
    rx_s2_d = rx_s1_q;
    rx_prev_d = rx_s2_q;
    rx_edge = rx_s2_q ^ rx_prev_q;
    wd_hit = 1'b0;
    to_hit = 1'b0;
    wd_arm_d = wd_arm_q;
    to_arm_d = to_arm_q;
    // Inactivity count restarts on any edge
    if (rx_edge) begin
      wd_cnt_d = '0;
      wd_arm_d = 1'b1;
    end else if (wd_cnt_q >= inactivity_duration_field) begin
      wd_cnt_d = wd_cnt_q;
      wd_hit = wd_arm_q;
      wd_arm_d = 1'b0;
    end else begin
      wd_cnt_d = wd_cnt_q + 1'b1;
    end
    // Timeout counts only while between frames; more than 16 bit periods
    if (rx_edge || !rx_idle_between) begin
      to_cnt_d = '0;
      to_arm_d = 1'b1;
    end else if (to_cnt_q > TO_W'(TO_CYC)) begin
      to_cnt_d = to_cnt_q;
      to_hit = to_arm_q;
      to_arm_d = 1'b0;
    end else begin
      to_cnt_d = to_cnt_q + 1'b1;
    end
  end

  // Register the link monitor state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_prev_q <= 1'b1;
      wd_cnt_q <= '0;
      to_cnt_q <= '0;
      wd_arm_q <= 1'b1;
      to_arm_q <= 1'b1;
    end else begin
      rx_s1_q <= rx_s1_d;
      rx_s2_q <= rx_s2_d;
      rx_prev_q <= rx_prev_d;
      wd_cnt_q <= wd_cnt_d;
      to_cnt_q <= to_cnt_d;
      wd_arm_q <= wd_arm_d;
      to_arm_q <= to_arm_d;
    end
  end

  // Decode writes and build set and clear masks
  always_comb begin
    wr_ser = reg_wr && (reg_addr == lfus_pkg::ADDR_SERIAL_ERR);
    wr_sh = reg_wr && (reg_addr == lfus_pkg::ADDR_SHORT);
    wr_op = reg_wr && (reg_addr == lfus_pkg::ADDR_OPEN);
    wr_tr = reg_wr && (reg_addr == lfus_pkg::ADDR_TRACE);
    ser_set = lfus_pkg::RST_VAL;
    ser_set[lfus_pkg::BIT_WATCHDOG] = wd_hit;
    ser_set[lfus_pkg::BIT_TIMEOUT] = to_hit;
    ser_set[lfus_pkg::BIT_CHECKSUM] = checksum_fail;
    ser_set[lfus_pkg::BIT_SYNC_PAR] = sync_frame_parity_err;
    ser_set[lfus_pkg::BIT_PL_PAR] = payload_parity_err;
    ser_set[lfus_pkg::BIT_SYNC_STOP] = sync_frame_stop_err;
    ser_set[lfus_pkg::BIT_PL_STOP] = payload_stopbit_err;
    ser_set[lfus_pkg::BIT_PL_START] = payload_startbit_err;
    // Write one clears; unimplemented bits ignore writes
    ser_clr = wr_ser ? (reg_wdata & lfus_pkg::SERIAL_MASK) : lfus_pkg::RST_VAL;
    sh_clr = wr_sh ? reg_wdata[11:0] : 12'h000;
    op_clr = wr_op ? reg_wdata[11:0] : 12'h000;
    tr_clr = wr_tr ? reg_wdata[11:0] : 12'h000;
  end

  // Serial error flags; unused bits never set so stay zero
  lfus_flag_bank #(.W(lfus_pkg::REG_W)) u_ser (
    .core_clk(core_clk),
    .rst(rst),
    .set_i(ser_set),
    .clr_i(ser_clr),
    .flags_q(ser_flags)
  );

  // Short vector, one bit per driver
  lfus_flag_bank #(.W(lfus_pkg::DRV_N)) u_short (
    .core_clk(core_clk),
    .rst(rst),
    .set_i(short_detect),
    .clr_i(sh_clr),
    .flags_q(sh_flags)
  );

  // Open vector, one bit per driver
  lfus_flag_bank #(.W(lfus_pkg::DRV_N)) u_open (
    .core_clk(core_clk),
    .rst(rst),
    .set_i(open_detect),
    .clr_i(op_clr),
    .flags_q(op_flags)
  );

  // Open trace vector
  lfus_flag_bank #(.W(lfus_pkg::DRV_N)) u_trace (
    .core_clk(core_clk),
    .rst(rst),
    .set_i(trace_detect),
    .clr_i(tr_clr),
    .flags_q(tr_flags)
  );

  // Read mux, reject, force and summaries
  always_comb begin
    rvalid_d = reg_rd;
    case (reg_addr)
      lfus_pkg::ADDR_SERIAL_ERR: rdata_d = ser_flags;
      lfus_pkg::ADDR_SHORT: rdata_d = {1'b0, sh_flags};
      lfus_pkg::ADDR_OPEN: rdata_d = {1'b0, op_flags};
      lfus_pkg::ADDR_TRACE: rdata_d = {1'b0, tr_flags};
      default: rdata_d = lfus_pkg::RST_VAL;
    endcase
    if (!reg_rd) begin
      rdata_d = reg_rdata_q; // Hold last answer between reads
    end
    reject_d = checksum_fail;
    // Forced state holds until the line moves again
    force_d = to_hit ? 1'b1 : (rx_edge ? 1'b0 : force_wd_state_q);
    // Summaries lag flags by one cycle since outputs are registered
    sum_ser_d = |ser_flags;
    sum_tr_d = |tr_flags;
    sum_op_d = |op_flags;
    sum_sh_d = |sh_flags;
  end

  // Output registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata_q <= lfus_pkg::RST_VAL;
      reg_rvalid_q <= 1'b0;
      reject_q <= 1'b0;
      force_wd_state_q <= 1'b0;
      any_serial_summary_q <= 1'b0;
      open_trace_summary_q <= 1'b0;
      any_open_summary_q <= 1'b0;
      any_short_summary_q <= 1'b0;
    end else begin
      reg_rdata_q <= rdata_d;
      reg_rvalid_q <= rvalid_d;
      reject_q <= reject_d;
      force_wd_state_q <= force_d;
      any_serial_summary_q <= sum_ser_d;
      open_trace_summary_q <= sum_tr_d;
      any_open_summary_q <= sum_op_d;
      any_short_summary_q <= sum_sh_d;
    end
  end
endmodule

// ===== testbench/lfus_status_regs_properties.sv
// Port-level assertions for the status register group
`timescale 1ns/1ps
module lfus_status_regs_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Event and detect inputs
  input wire logic checksum_fail,
  input wire logic sync_frame_parity_err,
  input wire logic [11:0] short_detect,
  input wire logic [11:0] open_detect,
  input wire logic [11:0] trace_detect,
  // Register access
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [12:0] reg_rdata_q,
  input wire logic reg_rvalid_q,
  // Status outputs
  input wire logic reject_q,
  input wire logic force_wd_state_q,
  input wire logic any_serial_summary_q,
  input wire logic open_trace_summary_q,
  input wire logic any_open_summary_q,
  input wire logic any_short_summary_q
);
  // One clock domain, so clocking and disable are shared
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_rd_ans; reg_rd |=> reg_rvalid_q; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_no_ans; !reg_rd |=> !reg_rvalid_q; endproperty
  a_no_ans: assert property (p_no_ans) else $error("stray read valid");
  property p_rej; checksum_fail |=> reject_q; endproperty
  a_rej: assert property (p_rej) else $error("bad checksum not rejected");
  property p_no_rej; !checksum_fail |=> !reject_q; endproperty
  a_no_rej: assert property (p_no_rej) else $error("stray reject");
  property p_sum_short; |short_detect |-> ##2 any_short_summary_q; endproperty
  a_sum_short: assert property (p_sum_short) else $error("short summary low");
  property p_sum_open; |open_detect |-> ##2 any_open_summary_q; endproperty
  a_sum_open: assert property (p_sum_open) else $error("open summary low");
  property p_sum_trace; |trace_detect |-> ##2 open_trace_summary_q; endproperty
  a_sum_trace: assert property (p_sum_trace) else $error("trace summary low");
  property p_sum_ser; sync_frame_parity_err |-> ##2 any_serial_summary_q; endproperty
  a_sum_ser: assert property (p_sum_ser) else $error("serial summary low");
  // Unmapped reads must come back empty
  property p_unmap;
    reg_rd && (reg_addr < lfus_pkg::ADDR_SERIAL_ERR || reg_addr > lfus_pkg::ADDR_TRACE) |=> reg_rdata_q == 13'h0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // Unused serial bits never read as one
  property p_resv; reg_rd && reg_addr == lfus_pkg::ADDR_SERIAL_ERR |=> (reg_rdata_q & ~lfus_pkg::SERIAL_MASK) == 0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved serial bit set");
  // Main scenarios reached
  c_rej: cover property (reject_q);
  c_force: cover property (force_wd_state_q);
  c_data: cover property (reg_rvalid_q && reg_rdata_q != 13'h0000);
endmodule
bind lfus_status_regs lfus_status_regs_properties u_chk (.core_clk(core_clk), .rst(rst),
  .checksum_fail(checksum_fail), .sync_frame_parity_err(sync_frame_parity_err), .short_detect(short_detect),
  .open_detect(open_detect), .trace_detect(trace_detect), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .reject_q(reject_q), .force_wd_state_q(force_wd_state_q),
  .any_serial_summary_q(any_serial_summary_q), .open_trace_summary_q(open_trace_summary_q),
  .any_open_summary_q(any_open_summary_q), .any_short_summary_q(any_short_summary_q));

// ===== testbench/lfus_link_model.sv
// Host side of the serial link, drives the receive pin
`timescale 1ns/1ps
module lfus_link_model #(
  parameter int CYC_PER_BIT = 2
) (
  // Clock
  input wire logic core_clk,
  // Receive pin and between-frames indication
  output logic rx_pin,
  output logic rx_idle_between
);
  // Line idles high; no frame seen yet, so not between frames
  initial begin
    rx_pin = 1'b1;
    rx_idle_between = 1'b0;
  end
  // Start bit, data LSB first, stop bit, then back to idle high
  task automatic send_frame(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    rx_idle_between = 1'b0;
    for (int i = 0; i < 10; i++) begin
      rx_pin = f[i];
      repeat (CYC_PER_BIT) @(posedge core_clk);
      #1;
    end
    rx_idle_between = 1'b1;
  endtask
endmodule

// ===== testbench/lfus_status_regs_test.sv
// Self-checking bench for the status register group
`timescale 1ns/1ps
module lfus_status_regs_test;
  logic core_clk, rst, reg_wr, reg_rd, reg_rvalid_q, reject_q, force_wd_state_q, rx_pin, rx_idle_between;
  logic [5:0] ev; // Serial events, bit i lands at flag 6-i
  logic [11:0] det [1:3]; // Short, open, trace detects
  logic [11:0] v;
  logic [7:0] reg_addr;
  logic [12:0] reg_wdata, reg_rdata_q;
  logic [15:0] wd_len;
  logic [3:0] sums; // Serial, short, open, trace summaries
  int exp_reg [4]; // Reference model, index is address minus 0x11
  int bad_count, n_checks;
  // Small bit period keeps the timeout short
  lfus_status_regs #(.CYC_PER_BIT(2)) dut (.core_clk(core_clk), .rst(rst), .rx_pin(rx_pin),
    .rx_idle_between(rx_idle_between), .checksum_fail(ev[0]), .sync_frame_parity_err(ev[1]),
    .payload_parity_err(ev[2]), .sync_frame_stop_err(ev[3]), .payload_stopbit_err(ev[4]),
    .payload_startbit_err(ev[5]), .inactivity_duration_field(wd_len), .short_detect(det[1]),
    .open_detect(det[2]), .trace_detect(det[3]), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .reject_q(reject_q),
    .force_wd_state_q(force_wd_state_q), .any_serial_summary_q(sums[0]), .any_short_summary_q(sums[1]),
    .any_open_summary_q(sums[2]), .open_trace_summary_q(sums[3]));
  lfus_link_model #(.CYC_PER_BIT(2)) link (.core_clk(core_clk), .rx_pin(rx_pin), .rx_idle_between(rx_idle_between));
  // Clock at 100 ns
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    n_checks++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Write one word; host clears by writing ones
  task automatic wr(input logic [7:0] a, input logic [12:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    if (a >= 8'h11 && a <= 8'h14) exp_reg[a-8'h11] &= ~int'(d);
  endtask
  // Read one word, bounded wait for the valid strobe
  task automatic rd(input logic [7:0] a);
    int k;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    for (k = 0; k < 4 && reg_rvalid_q !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
    if (k == 4) begin
      bad_count++;
      close_out();
    end
    chk("rdata", (a >= 8'h11 && a <= 8'h14) ? 13'(exp_reg[a-8'h11]) : 13'h0000, reg_rdata_q);
  endtask
  // Pulse detects and events for one cycle
  task automatic tick;
    @(posedge core_clk);
    #1;
    ev = 6'h00;
    det = '{12'h000, 12'h000, 12'h000};
  endtask
  initial begin
    {rst, reg_wr, reg_rd, ev, reg_addr, reg_wdata} = {1'b1, 29'h0};
    det = '{12'h000, 12'h000, 12'h000};
    wd_len = 16'hffff;
    exp_reg = '{0, 0, 0, 0};
    {bad_count, n_checks} = 64'h0;
    void'($urandom(32'h390a));
    repeat (16) @(posedge core_clk);
    #1;
    rst = 1'b0;
    for (int a = 8'h10; a <= 8'h15; a++) begin
      rd(8'(a));
      tick(); // Idle cycle so the read strobe is not lowered and raised in one step
    end
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      ev[i] = 1'b1;
      tick();
      chk("reject", 13'(i == 0), 13'(reject_q));
      exp_reg[0] |= 1 << (6 - i);
      rd(8'h11);
      chk("serial summary", 13'h0001, 13'(sums[0]));
      wr(8'h11, 13'(1 << (6 - i)));
      rd(8'h11);
    end
    $display("test serial events done");
    for (int r = 1; r <= 3; r++) begin
      v = 12'($urandom) | 12'h001;
      det[r] = v;
      tick();
      exp_reg[r] |= int'(v);
      rd(8'(8'h11 + r));
      chk("summary", 13'h0001, 13'(sums[r]));
      wr(8'(8'h11 + r), 13'($urandom));
      rd(8'(8'h11 + r));
      wr(8'(8'h11 + r), 13'h1fff);
      rd(8'(8'h11 + r));
      chk("summary clear", 13'h0000, 13'(sums[r]));
    end
    $display("test fault vectors done");
    det[1] = 12'h001;
    wr(8'h12, 13'h0001);
    det[1] = 12'h000;
    exp_reg[1] = 1;
    rd(8'h12);
    wr(8'h12, 13'h0001);
    $display("test set over clear done");
    wd_len = 16'd20;
    link.send_frame(8'h5a);
    repeat (30) @(posedge core_clk);
    #1;
    chk("force early", 13'h0000, 13'(force_wd_state_q));
    repeat (20) @(posedge core_clk);
    #1;
    chk("force state", 13'h0001, 13'(force_wd_state_q));
    exp_reg[0] |= 32'h180;
    rd(8'h11);
    link.send_frame(8'ha5);
    chk("force release", 13'h0000, 13'(force_wd_state_q));
    wr(8'h11, 13'h0180);
    rd(8'h11);
    $display("test link silence done");
    close_out();
  end
endmodule
